// File: design/scas_defines.svh
// timing constants and counter width for the smart card activation sequencer
`ifndef SCAS_DEFINES_SVH
`define SCAS_DEFINES_SVH
`define SCAS_CLK_PERIOD_NS 10
`define SCAS_FAULT_WINDOW_NS 5000
`define SCAS_FAULT_CYC ((`SCAS_FAULT_WINDOW_NS + `SCAS_CLK_PERIOD_NS - 1) / `SCAS_CLK_PERIOD_NS)
`define SCAS_DEBOUNCE_MS 40
`define SCAS_DEBOUNCE_CYC (`SCAS_DEBOUNCE_MS * 1000000 / `SCAS_CLK_PERIOD_NS)
`define SCAS_REMOVE_US 50
`define SCAS_REMOVE_CYC (`SCAS_REMOVE_US * 1000 / `SCAS_CLK_PERIOD_NS)
`define SCAS_CNT_W 23
`endif

// File: design/scas_pkg.sv
// types of the smart card activation sequencer
package scas_pkg;
   typedef enum logic [1:0] {
      SCAS_IDLE    = 2'h0,
      SCAS_ACTIVE  = 2'h1,
      SCAS_FAULT   = 2'h3,
      SCAS_ALARM   = 2'h2
   } scas_state_e;
   // one open-drain side of the three channels
   typedef struct packed {
      logic [2:0] drive_low;
   } scas_chan_s;
   // channel arbitration state
   typedef enum logic [1:0] {
      SCAS_CH_FREE  = 2'h0,
      SCAS_CH_HOST  = 2'h1,
      SCAS_CH_CARD  = 2'h2
   } scas_chan_e;
endpackage

// File: design/scas_top.sv
// smart card activation sequencer and bidirectional channel arbiter
//
// Overview of operation
// RQ1 - channels pass low one direction, first wins
// RQ2 - opposite low before release is collision
// RQ3 - collision: slave held low, master released
// RQ4 - slave-side external low never returns
// RQ5 - overtemperature disables and asserts alarm
// RQ6 - card present tied to request self-starts
// RQ7 - card removal triggers deactivation
// RQ8 - host idles lines before dropping request
// RQ9 - request high runs deactivation sequence
// RQ10 - confirmed fault runs deactivation itself
// RQ11 - idle drives card low, floats host
// RQ12 - deactivation runs until supply discharged
// RQ13 - activation ignored until discharge done
// RQ14 - alarm state exits only on release
// RQ15 - request cycling clears alarm, waits discharge
// RQ16 - active: latched voltage, pass reset/clock
// RQ17 - channels usable only after ready low
// RQ18 - persistent fault beyond window goes alarm
// RQ19 - short fault returns to active
// RQ20 - host holds sync clock while switching
// RQ21 - host releases lines when possible
// RQ22 - voltage select latched on request fall
// RQ23 - card present after debounce, quick release
// RQ24 - presence from switch xor polarity select
// RQ25 - fault window counter clears with fault
`timescale 1ns/10ps
`include "scas_defines.svh"
module scas_top #(
   parameter int FAULT_CYC = `SCAS_FAULT_CYC,
   parameter int DEBOUNCE_CYC = `SCAS_DEBOUNCE_CYC,
   parameter int REMOVE_CYC = `SCAS_REMOVE_CYC
) (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   // host control pins
   input wire logic I_POWER_REQUEST_N,
   input wire logic I_SUPPLY_VOLTAGE_SEL,
   input wire logic I_HOST_RESET_IN,
   input wire logic I_HOST_CLOCK_IN,
   input wire logic I_CLOCK_SOURCE_SEL,
   // socket and analog status
   input wire logic I_SOCKET_SWITCH_IN,
   input wire logic I_SWITCH_POLARITY,
   input wire logic I_OVERTEMP,
   input wire logic I_SUPPLY_FAULT,
   input wire logic I_SUPPLY_DISCHARGED,
   input wire logic I_SUPPLY_GOOD,
   // bidirectional channels: data, aux a, aux b
   input wire logic [2:0] I_HOST_CH,
   output logic [2:0] O_HOST_CH,
   output logic [2:0] O_HOST_CH_OE,
   input wire logic [2:0] I_CARD_CH,
   output logic [2:0] O_CARD_CH,
   output logic [2:0] O_CARD_CH_OE,
   // card supply, reset and clock
   output logic O_SUPPLY_EN,
   output logic O_SUPPLY_5V,
   output logic O_CARD_RESET,
   output logic O_CARD_CLOCK,
   output logic O_CLOCK_SOURCE_SEL,
   // status pins, open drain, and the driven state output
   output logic O_READY_N,
   output logic O_READY_N_OE,
   output logic O_ALARM_N,
   output logic O_ALARM_N_OE,
   output logic O_CARD_PRESENT_N,
   output logic O_CARD_PRESENT_N_OE,
   output logic [1:0] O_STATE
);
   //--------------------------------------------------------------
   // reset release and input synchronisers
   //--------------------------------------------------------------
   logic [1:0] rst_q;
   logic rst_n;
   localparam int NIN = 12;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] s1_q;
   logic [NIN-1:0] s2_q;
   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];
   assign raw_in = {I_HOST_CH, I_CARD_CH, I_POWER_REQUEST_N, I_SUPPLY_VOLTAGE_SEL,
                    I_SOCKET_SWITCH_IN, I_SWITCH_POLARITY, I_OVERTEMP, I_SUPPLY_FAULT};
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         // idle levels: channels and request high, rest low
         s1_q <= 12'hFE0;
         s2_q <= 12'hFE0;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
      end
   end
   logic [2:0] host_in;
   logic [2:0] card_in;
   logic pwr_n;
   logic vsel;
   logic sw;
   logic pol;
   logic otemp;
   logic sfault;
   assign {host_in, card_in, pwr_n, vsel, sw, pol, otemp, sfault} = s2_q;
   logic disch_s1_q;
   logic disch_q;
   logic good_s1_q;
   logic good_q;
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         disch_s1_q <= 1'b0;
         disch_q <= 1'b0;
         good_s1_q <= 1'b0;
         good_q <= 1'b0;
      end else begin
         disch_s1_q <= I_SUPPLY_DISCHARGED;
         disch_q <= disch_s1_q;
         good_s1_q <= I_SUPPLY_GOOD;
         good_q <= good_s1_q;
      end
   end

   //--------------------------------------------------------------
   // card presence debounce
   //--------------------------------------------------------------
   logic seen;
   logic present_q;
   logic present_d;
   logic [`SCAS_CNT_W-1:0] deb_q;
   logic [`SCAS_CNT_W-1:0] deb_d;
   assign seen = sw ^ pol; // [RQ24]
   always_comb begin
      present_d = present_q;
      deb_d = deb_q;
      if (seen == present_q) begin
         deb_d = '0;
      end else if (present_q) begin
         // removal, release quickly
         if (deb_q >= `SCAS_CNT_W'(REMOVE_CYC - 1)) begin // [RQ23]
            present_d = 1'b0;
            deb_d = '0;
         end else begin
            deb_d = deb_q + 1'b1;
         end
      end else if (deb_q >= `SCAS_CNT_W'(DEBOUNCE_CYC - 1)) begin // [RQ23]
         present_d = 1'b1;
         deb_d = '0;
      end else begin
         deb_d = deb_q + 1'b1;
      end
   end
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         present_q <= 1'b0;
         deb_q <= '0;
      end else begin
         present_q <= present_d;
         deb_q <= deb_d;
      end
   end

   //--------------------------------------------------------------
   // activation state machine
   //--------------------------------------------------------------
   scas_pkg::scas_state_e st_q;
   scas_pkg::scas_state_e st_d;
   logic [12:0] flt_q;
   logic [12:0] flt_d;
   logic vsel_q;
   logic vsel_d;
   logic pwr_q;
   logic fault;
   assign fault = otemp | sfault | !present_q; // [RQ7]
   always_comb begin
      st_d = st_q;
      flt_d = '0;
      vsel_d = vsel_q;
      if (pwr_q && !pwr_n) begin
         vsel_d = vsel; // [RQ22]
      end
      case (st_q)
         scas_pkg::SCAS_IDLE: begin
            // activation only after discharge and with a card
            if (!pwr_n && disch_q && present_q && !otemp) begin // [RQ13] [RQ12] [RQ6]
               st_d = scas_pkg::SCAS_ACTIVE;
            end
         end
         scas_pkg::SCAS_ACTIVE: begin
            if (pwr_n) begin
               st_d = scas_pkg::SCAS_IDLE; // [RQ9]
            end else if (otemp) begin
               st_d = scas_pkg::SCAS_ALARM; // [RQ5]
            end else if (fault) begin
               st_d = scas_pkg::SCAS_FAULT;
            end
         end
         scas_pkg::SCAS_FAULT: begin
            flt_d = flt_q + 1'b1; // [RQ25]
            if (pwr_n) begin
               st_d = scas_pkg::SCAS_IDLE;
            end else if (otemp) begin
               st_d = scas_pkg::SCAS_ALARM; // [RQ5]
            end else if (!fault) begin
               st_d = scas_pkg::SCAS_ACTIVE; // [RQ19]
            end else if (flt_q >= 13'(FAULT_CYC - 1)) begin
               st_d = scas_pkg::SCAS_ALARM; // [RQ18] [RQ10]
            end
         end
         scas_pkg::SCAS_ALARM: begin
            if (pwr_n) begin
               st_d = scas_pkg::SCAS_IDLE; // [RQ14] [RQ15]
            end
         end
         default: begin
            st_d = scas_pkg::SCAS_IDLE;
         end
      endcase
   end
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= scas_pkg::SCAS_IDLE;
         flt_q <= '0;
         vsel_q <= 1'b0;
         pwr_q <= 1'b1;
      end else begin
         st_q <= st_d;
         flt_q <= flt_d;
         vsel_q <= vsel_d;
         pwr_q <= pwr_n;
      end
   end

   //--------------------------------------------------------------
   // bidirectional channel arbitration
   //--------------------------------------------------------------
   logic act;
   logic ready;
   assign act = (st_q == scas_pkg::SCAS_ACTIVE) || (st_q == scas_pkg::SCAS_FAULT);
   assign ready = act && good_q;
   scas_pkg::scas_chan_s host_drv;
   scas_pkg::scas_chan_s card_drv;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ch
         scas_pkg::scas_chan_e own_q;
         scas_pkg::scas_chan_e own_d;
         always_comb begin
            own_d = own_q;
            case (own_q)
               scas_pkg::SCAS_CH_FREE: begin
                  // host side takes priority on a tie
                  if (!host_in[g]) begin
                     own_d = scas_pkg::SCAS_CH_HOST; // [RQ1]
                  end else if (!card_in[g]) begin
                     own_d = scas_pkg::SCAS_CH_CARD; // [RQ1]
                  end
               end
               scas_pkg::SCAS_CH_HOST: begin
                  // ends once both sides high; card low meanwhile is collision
                  if (host_in[g] && card_in[g]) begin // [RQ2]
                     own_d = scas_pkg::SCAS_CH_FREE;
                  end
               end
               scas_pkg::SCAS_CH_CARD: begin
                  if (host_in[g] && card_in[g]) begin // [RQ2]
                     own_d = scas_pkg::SCAS_CH_FREE;
                  end
               end
               default: begin
                  own_d = scas_pkg::SCAS_CH_FREE;
               end
            endcase
            if (!ready) begin
               own_d = scas_pkg::SCAS_CH_FREE; // [RQ17]
            end
         end
         always_ff @(posedge I_CLOCK or negedge rst_n) begin
            if (!rst_n) begin
               own_q <= scas_pkg::SCAS_CH_FREE;
            end else begin
               own_q <= own_d;
            end
         end
         // slave follows master only; never driven back to master
         assign card_drv.drive_low[g] = (own_q == scas_pkg::SCAS_CH_HOST) && !host_in[g]; // [RQ3] [RQ4]
         assign host_drv.drive_low[g] = (own_q == scas_pkg::SCAS_CH_CARD) && !card_in[g]; // [RQ3] [RQ4]
      end
   endgenerate

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_SUPPLY_EN <= 1'b0;
         O_SUPPLY_5V <= 1'b0;
         O_CARD_RESET <= 1'b0;
         O_CARD_CLOCK <= 1'b0;
         O_CLOCK_SOURCE_SEL <= 1'b0;
         O_READY_N_OE <= 1'b0;
         O_ALARM_N_OE <= 1'b0;
         O_CARD_PRESENT_N_OE <= 1'b0;
         O_CARD_CH_OE <= 3'h0;
         O_HOST_CH_OE <= 3'h0;
      end else begin
         O_SUPPLY_EN <= act; // [RQ11] [RQ16]
         O_SUPPLY_5V <= act & vsel_q; // [RQ16]
         O_CARD_RESET <= act & I_HOST_RESET_IN; // [RQ16]
         O_CARD_CLOCK <= act & I_HOST_CLOCK_IN; // [RQ16]
         O_CLOCK_SOURCE_SEL <= I_CLOCK_SOURCE_SEL;
         O_READY_N_OE <= ready; // [RQ6]
         O_ALARM_N_OE <= (st_q == scas_pkg::SCAS_ALARM); // [RQ14] [RQ5]
         O_CARD_PRESENT_N_OE <= present_q; // [RQ23]
         // idle: card lines driven low; active: low only when relayed
         O_CARD_CH_OE <= act ? card_drv.drive_low : 3'h7; // [RQ11]
         O_HOST_CH_OE <= act ? host_drv.drive_low : 3'h0; // [RQ11]
      end
   end
   assign O_READY_N = 1'b0;
   assign O_ALARM_N = 1'b0;
   assign O_CARD_PRESENT_N = 1'b0;
   assign O_CARD_CH = 3'h0;
   assign O_HOST_CH = 3'h0;
   assign O_STATE = st_q;
endmodule

// File: verification/scas_monitor.sv
// concurrent checks on the ports of the sequencer top
`timescale 1ns/10ps
module scas_monitor #(
   parameter int FAULT_CYC = 500
) (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   // watched inputs
   input wire logic I_POWER_REQUEST_N,
   input wire logic I_HOST_CLOCK_IN,
   input wire logic I_OVERTEMP,
   input wire logic I_SUPPLY_DISCHARGED,
   // watched outputs
   input wire logic [2:0] O_HOST_CH_OE,
   input wire logic [2:0] O_CARD_CH_OE,
   input wire logic O_SUPPLY_EN,
   input wire logic O_CARD_CLOCK,
   input wire logic O_READY_N_OE,
   input wire logic O_ALARM_N_OE,
   input wire logic [1:0] O_STATE
);
   logic [12:0] fault_cnt_q;
   logic [12:0] fault_cnt_d;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   // ----------------------------------------
   // cycles spent in fault timeout
   // ----------------------------------------
   always_comb begin
      fault_cnt_d = (O_STATE == 2'h3) ? fault_cnt_q + 13'h0001 : 13'h0000;
   end
   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         fault_cnt_q <= 13'h0000;
      end else begin
         fault_cnt_q <= fault_cnt_d;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   idle_outputs_a: assert property ($past(O_STATE) == 2'h0 && O_STATE == 2'h0
      |-> !O_SUPPLY_EN && !O_READY_N_OE && !O_ALARM_N_OE && O_HOST_CH_OE == 3'h0) else $error("idle drive wrong");
   alarm_early_a: assert property ($past(O_STATE) == 2'h3 && O_STATE == 2'h2 && !$past(I_OVERTEMP, 3)
      |-> int'(fault_cnt_q) >= FAULT_CYC - 3) else $error("fault window cut short");
   alarm_held_a: assert property ($past(O_STATE) == 2'h2 && O_STATE == 2'h2
      |-> O_ALARM_N_OE && !O_SUPPLY_EN) else $error("alarm state outputs wrong");
   alarm_exit_a: assert property ($past(O_STATE) == 2'h2 && O_STATE != 2'h2 |-> O_STATE == 2'h0)
      else $error("alarm left for non idle state");
   overtemp_alarm_a: assert property (O_STATE == 2'h1 && I_OVERTEMP |-> ##[1:4] O_STATE == 2'h2)
      else $error("overtemperature not alarmed");
   release_idle_a: assert property ($rose(I_POWER_REQUEST_N) |-> ##[1:5] O_STATE == 2'h0)
      else $error("request release did not deactivate");
   discharge_wait_a: assert property ((!I_SUPPLY_DISCHARGED) [*5] ##0 O_STATE == 2'h0 |=> O_STATE == 2'h0)
      else $error("activated before discharge");
   clock_pass_a: assert property ($past(O_STATE[0]) && O_STATE[0]
      |-> O_CARD_CLOCK == $past(I_HOST_CLOCK_IN)) else $error("card clock not following host");
   one_way_a: assert property ((O_HOST_CH_OE & O_CARD_CH_OE) == 3'h0)
      else $error("channel driven both ways");
endmodule

// File: verification/scas_card_model.sv
// card side: socket contacts and a card supply that ramps and discharges
`timescale 1ns/10ps
module scas_card_model (
   // clock
   input wire logic clk,
   // from the sequencer
   input wire logic supply_en,
   input wire logic [2:0] card_oe,
   // from the bench
   input wire logic [2:0] card_pull,
   input wire logic stall,
   // to the sequencer
   output logic [2:0] card_ch,
   output logic supply_good,
   output logic supply_discharged
);
   logic [2:0] level_q = 3'h0;
   assign card_ch = ~(card_oe | card_pull);
   assign supply_good = (level_q == 3'h7);
   assign supply_discharged = (level_q == 3'h0);
   // stall freezes the supply level, a slow discharge
   always @(posedge clk) begin
      if (!stall && supply_en && level_q != 3'h7) begin
         level_q <= level_q + 3'h1;
      end else if (!stall && !supply_en && level_q != 3'h0) begin
         level_q <= level_q - 3'h1;
      end
   end
endmodule

// File: verification/scas_top_tb.sv
// self-checking bench of the smart card activation sequencer
`timescale 1ns/10ps
module scas_top_tb;
   localparam int FAULT_CYC = 8;
   logic clk, nrst, req_n, self_start, sel, hclk, sw, otemp, sfault, stall, good, dis;
   logic [2:0] host_pull, card_pull, host_ch, card_ch, host_oe, card_oe;
   logic sup_en, sup5, cclk, rdy_oe, alm_oe, socket_switch_in_oe, hrst, csel, crst, csel_o, pol;
   logic [8:0] lv;
   logic [1:0] state;
   int miscompares = 0;
   int n_compared = 0;
   assign host_ch = ~(host_oe | host_pull);
   scas_top #(.FAULT_CYC(FAULT_CYC), .DEBOUNCE_CYC(20), .REMOVE_CYC(4)) dut_u (
      .I_CLOCK(clk), .I_NRST(nrst), .I_POWER_REQUEST_N(self_start ? !socket_switch_in_oe : req_n),
      .I_SUPPLY_VOLTAGE_SEL(sel), .I_HOST_RESET_IN(hrst), .I_HOST_CLOCK_IN(hclk), .I_CLOCK_SOURCE_SEL(csel),
      .I_SOCKET_SWITCH_IN(sw), .I_SWITCH_POLARITY(pol), .I_OVERTEMP(otemp), .I_SUPPLY_FAULT(sfault),
      .I_SUPPLY_DISCHARGED(dis), .I_SUPPLY_GOOD(good), .I_HOST_CH(host_ch), .O_HOST_CH(lv[5:3]),
      .O_HOST_CH_OE(host_oe), .I_CARD_CH(card_ch), .O_CARD_CH(lv[2:0]), .O_CARD_CH_OE(card_oe),
      .O_SUPPLY_EN(sup_en), .O_SUPPLY_5V(sup5), .O_CARD_RESET(crst), .O_CARD_CLOCK(cclk),
      .O_CLOCK_SOURCE_SEL(csel_o), .O_READY_N(lv[8]), .O_READY_N_OE(rdy_oe), .O_ALARM_N(lv[7]),
      .O_ALARM_N_OE(alm_oe), .O_CARD_PRESENT_N(lv[6]), .O_CARD_PRESENT_N_OE(socket_switch_in_oe), .O_STATE(state));
   scas_card_model card_u (.clk(clk), .supply_en(sup_en), .card_oe(card_oe), .card_pull(card_pull),
      .stall(stall), .card_ch(card_ch), .supply_good(good), .supply_discharged(dis));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   initial begin
      {nrst, self_start, sel, hclk, sw, otemp, sfault, stall} = 8'h20;
      req_n = 1'b1;
      {hrst, csel, pol} = 3'h0;
      host_pull = 3'h0;
      card_pull = 3'h0;
      step(12);
      nrst = 1'b1;
      step(6);
      chk({card_oe, sup_en, rdy_oe, alm_oe, host_oe}, 16'h01C0);
      chk(lv, 16'h0000);
      sw = 1'b1;
      step(10);
      chk(socket_switch_in_oe, 8'h00);
      step(20);
      chk(socket_switch_in_oe, 8'h01);
      self_start = 1'b1;
      step(25);
      chk({state, sup5, rdy_oe}, 8'h07);
      sel = 1'b0;
      hclk = 1'b1;
      hrst = 1'b1;
      step(4);
      chk({sup5, cclk, crst}, 16'h0007);
      host_pull = 3'h1;
      csel = 1'b1;
      step(5);
      chk({card_oe, host_oe}, 8'h08);
      chk(csel_o, 16'h0001);
      card_pull = 3'h1;
      step(5);
      chk({card_oe, host_oe}, 8'h08);
      host_pull = 3'h0;
      step(5);
      chk({card_oe, host_oe}, 8'h00);
      card_pull = 3'h0;
      step(5);
      card_pull = 3'h2;
      step(5);
      chk({card_oe, host_oe}, 8'h02);
      card_pull = 3'h0;
      sfault = 1'b1;
      step(4);
      chk(state, 8'h03);
      sfault = 1'b0;
      step(4);
      chk(state, 8'h01);
      sfault = 1'b1;
      stall = 1'b1;
      step(FAULT_CYC + 8);
      chk({state, alm_oe, sup_en, crst, cclk}, 16'h0028);
      sfault = 1'b0;
      step(10);
      chk(state, 8'h02);
      self_start = 1'b0;
      step(6);
      chk({state, alm_oe}, 8'h00);
      req_n = 1'b0;
      step(10);
      chk(state, 8'h00);
      stall = 1'b0;
      step(20);
      chk({state, sup5}, 8'h02);
      otemp = 1'b1;
      step(5);
      chk(state, 8'h02);
      otemp = 1'b0;
      hclk = 1'b0;
      hrst = 1'b0;
      step(1);
      req_n = 1'b1;
      step(6);
      chk(state, 8'h00);
      req_n = 1'b0;
      step(25);
      chk(state, 8'h01);
      pol = 1'b1;
      step(FAULT_CYC + 14);
      chk({state, sup_en, socket_switch_in_oe}, 8'h08);
      close_out();
   end
endmodule
bind scas_top scas_monitor #(.FAULT_CYC(FAULT_CYC)) mon_u (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
   .I_POWER_REQUEST_N(I_POWER_REQUEST_N), .I_HOST_CLOCK_IN(I_HOST_CLOCK_IN), .I_OVERTEMP(I_OVERTEMP),
   .I_SUPPLY_DISCHARGED(I_SUPPLY_DISCHARGED), .O_HOST_CH_OE(O_HOST_CH_OE), .O_CARD_CH_OE(O_CARD_CH_OE),
   .O_SUPPLY_EN(O_SUPPLY_EN), .O_CARD_CLOCK(O_CARD_CLOCK), .O_READY_N_OE(O_READY_N_OE),
   .O_ALARM_N_OE(O_ALARM_N_OE), .O_STATE(O_STATE));
